//--- rtl/disk_esc_pkg.sv
/*
 * Constants, addresses and state codes shared by the auxiliary command
 * interpreter and its diagnostic code memory.
 * Assumes a single 50 MHz clock domain and an active-low async reset.
 */
package disk_esc_pkg;

    // ------------------------------------------------------------------
    // Adapter byte addresses
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_AUX_CMD   = 3'h0;
    localparam logic [2:0] ADDR_DEV_ID    = 3'h0;
    localparam logic [2:0] ADDR_DIAG_CODE = 3'h1;
    localparam logic [2:0] ADDR_DETAIL    = 3'h2;
    localparam logic [2:0] ADDR_LOOPBACK  = 3'h0;
    localparam logic [2:0] ADDR_CYL_HIGH  = 3'h4;
    localparam logic [2:0] ADDR_HEAD      = 3'h5;
    localparam logic [2:0] ADDR_CYL_LOW   = 3'h6;

    // ------------------------------------------------------------------
    // Event command byte bits
    // ------------------------------------------------------------------
    localparam int EV_FAULT_RESET = 2;
    localparam int EV_TRACK_ZERO  = 4;
    localparam int EV_HEAD_SEL    = 5;
    localparam int EV_SEEK        = 6;
    localparam int EV_AUX_FETCH   = 7;

    // ------------------------------------------------------------------
    // Auxiliary command byte bits
    // ------------------------------------------------------------------
    localparam int AUX_DETAIL   = 0;
    localparam int AUX_DIAG     = 1;
    localparam int AUX_DEV_ID   = 2;
    localparam int AUX_LOOP     = 3;
    localparam int AUX_OFS_PLUS = 4;
    localparam int AUX_OFS_MIN  = 5;

    // ------------------------------------------------------------------
    // Head numbers, codes and memory size
    // ------------------------------------------------------------------
    localparam logic [7:0] HEAD_MAX        = 8'h03;
    localparam logic [1:0] HEAD_RESET      = 2'h0;
    localparam logic [7:0] SEEK_ERR_CODE   = 8'hE1;
    localparam logic [7:0] NO_CODE         = 8'h00;
    // Arbitrary identity value, not tied to any product.
    localparam logic [7:0] DEVICE_ID_VALUE = 8'h5A;
    localparam int         DIAG_DEPTH      = 16;
    localparam int         DIAG_AW         = 4;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_HEAD     = 4'h1,
        ST_CYL      = 4'h2,
        ST_AUX      = 4'h3,
        ST_DETAIL   = 4'h4,
        ST_DIAG     = 4'h5,
        ST_DEV_ID   = 4'h6,
        ST_LOOP_IN  = 4'h7,
        ST_LOOP_OUT = 4'h8,
        ST_DONE     = 4'h9
    } esc_state_t;

endpackage : disk_esc_pkg

//--- rtl/diag_code_mem.sv
/*
 * Sixteen-entry wrap-around store for diagnostic codes, oldest first.
 * A pop on an empty store is ignored; push on a full store
 * drops the oldest entry.
 */
`timescale 1ns/1ns
`default_nettype none

module diag_code_mem
    import disk_esc_pkg::*;
(
    input  wire logic           core_clk_i,
    input  wire logic           rst_b_i,
    input  wire logic           clear_i,
    input  wire logic           push_i,
    input  wire logic [7:0]     push_data_i,
    input  wire logic           pop_i,
    output logic      [7:0]     oldest_o,
    output logic      [7:0]     newest_o,
    output logic      [DIAG_AW:0] count_o
);

    logic [7:0]         mem_reg [DIAG_DEPTH];
    logic [7:0]         mem_next [DIAG_DEPTH];
    logic [DIAG_AW-1:0] rd_reg, rd_next, wr_reg, wr_next;
    logic [DIAG_AW:0]   cnt_reg, cnt_next;
    logic               full;

    assign full     = (cnt_reg == (DIAG_AW+1)'(DIAG_DEPTH));
    assign oldest_o = mem_reg[rd_reg];
    assign newest_o = mem_reg[wr_reg - 4'h1];
    assign count_o  = cnt_reg;

    always_comb begin
        mem_next = mem_reg;
        rd_next  = rd_reg;
        wr_next  = wr_reg;
        cnt_next = cnt_reg;
        if (clear_i) begin
            rd_next  = wr_reg;
            cnt_next = '0;
            // A code arriving with the clear survives as the only entry.
            if (push_i) begin
                mem_next[wr_reg] = push_data_i;
                wr_next          = wr_reg + 4'h1;
                cnt_next         = 5'h01;
            end
        end else begin
            if (pop_i && cnt_reg != '0) begin
                rd_next  = rd_reg + 4'h1;
                cnt_next = cnt_reg - 5'h01;
            end
            if (push_i) begin
                mem_next[wr_reg] = push_data_i;
                wr_next          = wr_reg + 4'h1;
                if (full && !pop_i) begin
                    rd_next = rd_reg + 4'h1;
                end else begin
                    cnt_next = cnt_next + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < DIAG_DEPTH; i++) begin
                mem_reg[i] <= 8'h00;
            end
            rd_reg  <= '0;
            wr_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            rd_reg  <= rd_next;
            wr_reg  <= wr_next;
            cnt_reg <= cnt_next;
        end
    end

endmodule : diag_code_mem

`default_nettype wire

//--- rtl/disk_escape_ctrl.sv
/*
 * Event and auxiliary command interpreter of the drive: fetches the head,
 * low cylinder and auxiliary command bytes from the adapter, runs the
 * auxiliary byte operations and keeps the diagnostic code store.
 * Assumes the adapter answers each byte request with a one-cycle ack.
 */
// Contract
// - Auxiliary byte is fetched from address 000; each bit is its own request.
// - Auxiliary byte is fetched only when event bit 7 is set.
// - Auxiliary bit 0 sends the detailed hardware status byte.
// - Auxiliary bit 1 sends one diagnostic code per event, oldest of sixteen first.
// - Codes are stored as they arise; a seek error stores its code newest. A trace code pushed in the same cycle as a seek error is dropped.
// - A diagnostic code is removed once sent to the adapter.
// - Fault reset in the event erases all codes before other operations.
// - Auxiliary bit 2 sends the identification byte.
// - Auxiliary bit 3 fetches low cylinder byte and sends it back to auxiliary address.
// - Servo offset bits cause no motion but still give completion status.
// - Byte-returning auxiliary commands suppress the completion status transfer.
// - Seek request in the event fetches the low cylinder byte.
// - High cylinder byte at address 100 is never used.
// - Head byte is binary: 0,1 removable, 2,3 fixed surfaces.
// - Head select request in the event fetches the head byte.
// - Head byte above 3 sets seek error until return to track zero.
`timescale 1ns/1ns
`default_nettype none

module disk_escape_ctrl
    import disk_esc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       event_valid_i,
    input  wire logic [7:0] event_byte_i,
    output logic            event_ready_o,
    output logic            xfer_req_o,
    output logic            xfer_dir_o,
    output logic      [2:0] xfer_addr_o,
    output logic      [7:0] xfer_wdata_o,
    input  wire logic       xfer_ack_i,
    input  wire logic [7:0] xfer_rdata_i,
    input  wire logic [7:0] detail_status_i,
    input  wire logic       trace_push_i,
    input  wire logic [7:0] trace_code_i,
    output logic            status_req_o,
    output logic            seek_error_o,
    output logic      [1:0] head_sel_o,
    output logic      [7:0] cyl_low_o,
    output logic            seek_start_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    esc_state_t       state_reg, state_next;
    logic [6:0]       work_reg, work_next;
    logic [7:0]       wdata_reg, wdata_next;
    logic             byte_cmd_reg, byte_cmd_next;
    logic             seek_err_reg, seek_err_next;
    logic [1:0]       head_reg, head_next;
    logic [7:0]       cyl_reg, cyl_next;
    logic             seek_pulse_reg, seek_pulse_next;
    logic             accept, ack_head, head_bad;
    logic             fifo_clear, fifo_push, fifo_pop;
    logic [7:0]       fifo_data, fifo_oldest, fifo_newest;
    logic [DIAG_AW:0] fifo_count;

    // Work bits: 0 head, 1 cylinder, 2 aux fetch, 3 detail, 4 code, 5 id, 6 loop.
    function automatic esc_state_t pick(input logic [6:0] w);
        pick = ST_DONE;
        for (int i = 6; i >= 0; i--) begin
            if (w[i]) begin
                pick = esc_state_t'(4'(i + 1));
            end
        end
    endfunction : pick

    assign accept   = event_valid_i && (state_reg == ST_IDLE);
    assign ack_head = (state_reg == ST_HEAD) && xfer_ack_i;
    assign head_bad = xfer_rdata_i > HEAD_MAX;

    // ------------------------------------------------------------------
    // Diagnostic code store
    // ------------------------------------------------------------------
    assign fifo_clear = accept && event_byte_i[EV_FAULT_RESET];
    // A seek error code takes the slot over a trace code so it is newest.
    assign fifo_push  = (ack_head && head_bad) || trace_push_i;
    assign fifo_data  = (ack_head && head_bad) ? SEEK_ERR_CODE : trace_code_i;
    assign fifo_pop   = (state_reg == ST_DIAG) && xfer_ack_i;

    diag_code_mem u_codes (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .clear_i     (fifo_clear),
        .push_i      (fifo_push),
        .push_data_i (fifo_data),
        .pop_i       (fifo_pop),
        .oldest_o    (fifo_oldest),
        .newest_o    (fifo_newest),
        .count_o     (fifo_count)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next      = state_reg;
        work_next       = work_reg;
        wdata_next      = wdata_reg;
        byte_cmd_next   = byte_cmd_reg;
        seek_err_next   = seek_err_reg;
        head_next       = head_reg;
        cyl_next        = cyl_reg;
        seek_pulse_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (accept) begin
                    byte_cmd_next = 1'b0;
                    if (event_byte_i[EV_TRACK_ZERO]) begin
                        seek_err_next = 1'b0;
                        head_next     = HEAD_RESET;
                    end
                    work_next = {4'h0, event_byte_i[EV_AUX_FETCH],
                                 event_byte_i[EV_SEEK],
                                 event_byte_i[EV_HEAD_SEL]};
                    state_next = pick(work_next);
                end
            end
            ST_HEAD: begin
                if (xfer_ack_i) begin
                    if (head_bad) begin
                        seek_err_next = 1'b1;
                    end else if (!seek_err_reg) begin
                        head_next = xfer_rdata_i[1:0];
                    end
                    work_next[0] = 1'b0;
                    state_next   = pick(work_next);
                end
            end
            ST_CYL: begin
                if (xfer_ack_i) begin
                    // Cylinder is ignored while a seek error is pending.
                    if (!seek_err_next) begin
                        cyl_next        = xfer_rdata_i;
                        seek_pulse_next = 1'b1;
                    end
                    work_next[1] = 1'b0;
                    state_next   = pick(work_next);
                end
            end
            ST_AUX: begin
                if (xfer_ack_i) begin
                    // Servo offset bits fall through with no action.
                    work_next     = {xfer_rdata_i[AUX_LOOP], xfer_rdata_i[AUX_DEV_ID],
                                     xfer_rdata_i[AUX_DIAG], xfer_rdata_i[AUX_DETAIL],
                                     3'h0};
                    byte_cmd_next = |xfer_rdata_i[AUX_LOOP:AUX_DETAIL];
                    state_next    = pick(work_next);
                end
            end
            ST_DETAIL, ST_DIAG, ST_DEV_ID: begin
                if (xfer_ack_i) begin
                    work_next[3'(state_reg - ST_HEAD)] = 1'b0;
                    state_next = pick(work_next);
                end
            end
            ST_LOOP_IN: begin
                if (xfer_ack_i) begin
                    wdata_next = xfer_rdata_i;
                    state_next = ST_LOOP_OUT;
                end
            end
            ST_LOOP_OUT: begin
                if (xfer_ack_i) begin
                    work_next[6] = 1'b0;
                    state_next   = pick(work_next);
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (state_next != state_reg) begin
            case (state_next)
                ST_DETAIL: wdata_next = detail_status_i;
                ST_DIAG:   wdata_next = (fifo_count == '0) ? NO_CODE : fifo_oldest;
                ST_DEV_ID: wdata_next = DEVICE_ID_VALUE;
                default:   wdata_next = wdata_next;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg      <= ST_IDLE;
            work_reg       <= '0;
            wdata_reg      <= 8'h00;
            byte_cmd_reg   <= 1'b0;
            seek_err_reg   <= 1'b0;
            head_reg       <= HEAD_RESET;
            cyl_reg        <= 8'h00;
            seek_pulse_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            work_reg       <= work_next;
            wdata_reg      <= wdata_next;
            byte_cmd_reg   <= byte_cmd_next;
            seek_err_reg   <= seek_err_next;
            head_reg       <= head_next;
            cyl_reg        <= cyl_next;
            seek_pulse_reg <= seek_pulse_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        xfer_req_o  = 1'b1;
        xfer_dir_o  = 1'b0;
        xfer_addr_o = ADDR_AUX_CMD;
        // The high cylinder address is never requested.
        case (state_reg)
            ST_HEAD:     xfer_addr_o = ADDR_HEAD;
            ST_CYL:      xfer_addr_o = ADDR_CYL_LOW;
            ST_AUX:      xfer_addr_o = ADDR_AUX_CMD;
            ST_LOOP_IN:  xfer_addr_o = ADDR_CYL_LOW;
            ST_DETAIL: begin
                xfer_dir_o  = 1'b1;
                xfer_addr_o = ADDR_DETAIL;
            end
            ST_DIAG: begin
                xfer_dir_o  = 1'b1;
                xfer_addr_o = ADDR_DIAG_CODE;
            end
            ST_DEV_ID: begin
                xfer_dir_o  = 1'b1;
                xfer_addr_o = ADDR_DEV_ID;
            end
            ST_LOOP_OUT: begin
                xfer_dir_o  = 1'b1;
                xfer_addr_o = ADDR_LOOPBACK;
            end
            default:     xfer_req_o = 1'b0;
        endcase
    end

    assign event_ready_o = (state_reg == ST_IDLE);
    assign xfer_wdata_o  = wdata_reg;
    assign status_req_o  = (state_reg == ST_DONE) && !byte_cmd_reg;
    assign seek_error_o  = seek_err_reg;
    assign head_sel_o    = head_reg;
    assign cyl_low_o     = cyl_reg;
    assign seek_start_o  = seek_pulse_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    // The aux byte is kept apart from byte_cmd_reg so the status check is independent.
    logic       ev_aux_reg;
    logic [3:0] aux_bits_reg;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ev_aux_reg   <= 1'b0;
            aux_bits_reg <= 4'h0;
        end else if (accept) begin
            ev_aux_reg   <= event_byte_i[EV_AUX_FETCH];
            aux_bits_reg <= 4'h0;
        end else if (state_reg == ST_AUX && xfer_ack_i) begin
            aux_bits_reg <= xfer_rdata_i[AUX_LOOP:AUX_DETAIL];
        end
    end

    a_aux_needs_bit7: assert property (state_reg == ST_AUX |-> ev_aux_reg)
        else $error("aux byte fetched without event bit 7");
    a_aux_fetch_addr: assert property (
        state_reg == ST_AUX |-> xfer_req_o && !xfer_dir_o && xfer_addr_o == ADDR_AUX_CMD)
        else $error("aux byte fetch on wrong address");
    a_head_bad_err: assert property (
        ack_head && head_bad |=> seek_error_o && fifo_newest == SEEK_ERR_CODE)
        else $error("bad head did not set seek error and code");
    a_seek_err_hold: assert property (
        seek_error_o && !(accept && event_byte_i[EV_TRACK_ZERO]) |=> seek_error_o)
        else $error("seek error dropped without return to track zero");
    a_fault_clear: assert property (fifo_clear |=> fifo_count <= 5'h01)
        else $error("fault reset did not erase codes");
    a_diag_pop_one: assert property (
        fifo_pop && !fifo_push && fifo_count != '0 |=> fifo_count == $past(fifo_count) - 5'h01)
        else $error("sent code not removed");
    a_loop_echo: assert property (
        state_reg == ST_LOOP_IN && xfer_ack_i
        |=> state_reg == ST_LOOP_OUT && xfer_wdata_o == $past(xfer_rdata_i))
        else $error("loopback byte not echoed");
    a_byte_no_status: assert property (
        state_reg == ST_DONE |-> status_req_o == (aux_bits_reg == 4'h0))
        else $error("completion status does not match the aux byte");
    a_head_apply: assert property (
        ack_head && !head_bad && !seek_err_reg |=> head_sel_o == $past(xfer_rdata_i[1:0]))
        else $error("valid head not applied");
    a_no_high_cyl: assert property (xfer_req_o |-> xfer_addr_o != ADDR_CYL_HIGH)
        else $error("high cylinder byte requested");
    a_cyl_fetch: assert property (
        accept && event_byte_i[EV_SEEK] |-> ##[1:300] state_reg == ST_CYL)
        else $error("seek did not fetch low cylinder");

    c_loopback:   cover property (state_reg == ST_LOOP_OUT && xfer_ack_i);
    c_diag_send:  cover property (fifo_pop && fifo_count != '0);
    c_head_error: cover property (ack_head && head_bad);
    c_status:     cover property (status_req_o);

endmodule : disk_escape_ctrl

`default_nettype wire

//--- dv/adapter_model.sv
/*
 * Behavioural host adapter that answers the drive's byte requests.
 * Assumes the drive holds its request until the ack is seen, and that
 * the bench loads the auxiliary byte only while the drive is idle.
 */
`timescale 1ns/1ns
`default_nettype none

module adapter_model
    import disk_esc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       xfer_req_i,
    input  wire logic [2:0] xfer_addr_i,
    input  wire logic [1:0] delay_i,
    input  wire logic       aux_load_i,
    input  wire logic [5:0] aux_val_i,
    input  wire logic [7:0] head_i,
    input  wire logic [7:0] cyl_i,
    output logic            xfer_ack_o,
    output logic      [7:0] xfer_rdata_o
);
    logic [7:0] aux_reg;
    logic [1:0] wait_cnt;

    // Between acks the byte lines are released, so they toggle instead of holding.
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aux_reg      <= 8'h00;
            wait_cnt     <= 2'h0;
            xfer_ack_o   <= 1'b0;
            xfer_rdata_o <= 8'h00;
        end else begin
            xfer_ack_o   <= 1'b0;
            xfer_rdata_o <= ~xfer_rdata_o;
            if (aux_load_i) begin
                aux_reg <= {2'b00, aux_val_i};
            end
            if (xfer_req_i && !xfer_ack_o) begin
                if (wait_cnt == delay_i) begin
                    xfer_ack_o <= 1'b1;
                    wait_cnt   <= 2'h0;
                    case (xfer_addr_i)
                        ADDR_AUX_CMD:  xfer_rdata_o <= aux_reg;
                        ADDR_HEAD:     xfer_rdata_o <= head_i;
                        ADDR_CYL_LOW:  xfer_rdata_o <= cyl_i;
                        ADDR_CYL_HIGH: xfer_rdata_o <= 8'hC3;
                        default:       xfer_rdata_o <= 8'h00;
                    endcase
                    if (xfer_addr_i == ADDR_AUX_CMD) begin
                        aux_reg <= 8'h00;
                    end
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
        end
    end
endmodule : adapter_model

`default_nettype wire

//--- dv/tb.sv
/*
 * Self-checking bench for the auxiliary command interpreter.
 * Assumes the adapter model answers every byte request within four cycles.
 */
`timescale 1ns/1ns
`default_nettype none

module tb;
    import disk_esc_pkg::*;

    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic event_valid = 1'b0, trace_push = 1'b0, aux_load = 1'b0, ack;
    logic [7:0] event_byte = 8'h00, trace_code = 8'h00, head_b = 8'h00, cyl_b = 8'h00, rdata;
    logic [7:0] detail = 8'h96;
    logic [5:0] aux_val = 6'h00;
    logic [1:0] delay = 2'h0;
    logic ready, req, dir, st_req, seek_err, seek_go;
    logic [2:0] addr;
    logic [7:0] wdata, cyl_low;
    logic [1:0] head_sel;
    logic [11:0] log_q[$];
    int miscompares = 0, comparisons = 0, st_cnt = 0, sk_cnt = 0, cyc = 0;

    always #10 core_clk_i = ~core_clk_i;

    disk_escape_ctrl disk_escape_ctrl_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .event_valid_i(event_valid), .event_byte_i(event_byte), .event_ready_o(ready),
        .xfer_req_o(req), .xfer_dir_o(dir), .xfer_addr_o(addr), .xfer_wdata_o(wdata),
        .xfer_ack_i(ack), .xfer_rdata_i(rdata), .detail_status_i(detail),
        .trace_push_i(trace_push), .trace_code_i(trace_code), .status_req_o(st_req),
        .seek_error_o(seek_err), .head_sel_o(head_sel), .cyl_low_o(cyl_low),
        .seek_start_o(seek_go));

    adapter_model adapter_model_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .xfer_req_i(req), .xfer_addr_i(addr), .delay_i(delay), .aux_load_i(aux_load),
        .aux_val_i(aux_val), .head_i(head_b), .cyl_i(cyl_b), .xfer_ack_o(ack),
        .xfer_rdata_o(rdata));

    // Each completed byte is logged as direction, address and data.
    always @(posedge core_clk_i) begin
        cyc++;
        if (req === 1'b1 && ack === 1'b1) log_q.push_back({dir, addr, dir ? wdata : rdata});
        if (st_req === 1'b1) st_cnt++;
        if (seek_go === 1'b1) sk_cnt++;
        if (cyc == 5000) begin
            miscompares++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic ev(input logic [7:0] b, input logic [5:0] aux, input logic [7:0] hd,
                      input logic [7:0] cy, input logic [1:0] dl);
        int n;
        @(negedge core_clk_i);
        aux_val = aux;
        detail = 8'h96 ^ {2'h0, aux};
        aux_load = 1'b1;
        head_b = hd;
        cyl_b = cy;
        delay = dl;
        log_q.delete();
        st_cnt = 0;
        sk_cnt = 0;
        @(negedge core_clk_i);
        aux_load = 1'b0;
        event_valid = 1'b1;
        event_byte = b;
        @(negedge core_clk_i);
        event_valid = 1'b0;
        n = 0;
        while (ready !== 1'b1 && n < 200) begin
            @(negedge core_clk_i);
            n++;
        end
        check(12'(n < 200), 12'h001);
    endtask : ev

    task automatic aux_case(input logic [7:0] b, input logic [5:0] aux, input int n,
                            input logic [11:0] e1, input logic [11:0] e2, input int st);
        ev(b, aux, 8'h00, 8'h3C, 2'(n));
        check(12'(log_q.size()), 12'(n));
        check(log_q[0], {1'b0, ADDR_AUX_CMD, 2'b00, aux});
        if (n > 1) check(log_q[1], e1);
        if (n > 2) check(log_q[2], e2);
        check(12'(st_cnt), 12'(st));
        check(12'(sk_cnt), 12'h000);
    endtask : aux_case

    task automatic push(input logic [7:0] c);
        @(negedge core_clk_i);
        trace_push = 1'b1;
        trace_code = c;
        @(negedge core_clk_i);
        trace_push = 1'b0;
    endtask : push

    initial begin
        repeat (8) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        ev(8'h00, 6'h3F, 8'h00, 8'h00, 2'h0);
        check(12'(log_q.size()), 12'h000);
        check(12'(st_cnt), 12'h001);
        for (int h = 0; h < 4; h++) begin
            ev(8'h20, 6'h00, 8'(h), 8'h00, 2'(h));
            check(log_q[0], {1'b0, ADDR_HEAD, 8'(h)});
            check({10'h000, head_sel}, 12'(h));
        end
        ev(8'h60, 6'h00, 8'h01, 8'hA5, 2'h2);
        check(12'(log_q.size()), 12'h002);
        check(log_q[1], {1'b0, ADDR_CYL_LOW, 8'hA5});
        check({4'h0, cyl_low}, 12'h0A5);
        check(12'(sk_cnt), 12'h001);
        aux_case(8'h80, 6'h01, 2, {1'b1, ADDR_DETAIL, 8'h97}, 12'h000, 0);
        aux_case(8'h80, 6'h04, 2, {1'b1, ADDR_DEV_ID, DEVICE_ID_VALUE}, 12'h000, 0);
        aux_case(8'h80, 6'h08, 3, {1'b0, ADDR_CYL_LOW, 8'h3C},
                 {1'b1, ADDR_LOOPBACK, 8'h3C}, 0);
        aux_case(8'h80, 6'h05, 3, {1'b1, ADDR_DETAIL, 8'h93},
                 {1'b1, ADDR_DEV_ID, DEVICE_ID_VALUE}, 0);
        aux_case(8'h80, 6'h10, 1, 12'h000, 12'h000, 1);
        aux_case(8'h80, 6'h20, 1, 12'h000, 12'h000, 1);
        ev(8'h04, 6'h00, 8'h00, 8'h00, 2'h0);
        push(8'h11);
        push(8'h22);
        push(8'h33);
        aux_case(8'h82, 6'h02, 2, {1'b1, ADDR_DIAG_CODE, 8'h11}, 12'h000, 0);
        aux_case(8'h82, 6'h02, 2, {1'b1, ADDR_DIAG_CODE, 8'h22}, 12'h000, 0);
        ev(8'h20, 6'h00, 8'h07, 8'h00, 2'h1);
        check({11'h000, seek_err}, 12'h001);
        aux_case(8'h82, 6'h02, 2, {1'b1, ADDR_DIAG_CODE, 8'h33}, 12'h000, 0);
        aux_case(8'h82, 6'h02, 2, {1'b1, ADDR_DIAG_CODE, SEEK_ERR_CODE}, 12'h000, 0);
        aux_case(8'h82, 6'h02, 2, {1'b1, ADDR_DIAG_CODE, NO_CODE}, 12'h000, 0);
        ev(8'h20, 6'h00, 8'h02, 8'h00, 2'h0);
        check({11'h000, seek_err}, 12'h001);
        check({10'h000, head_sel}, 12'h001);
        ev(8'h10, 6'h00, 8'h00, 8'h00, 2'h0);
        check({11'h000, seek_err}, 12'h000);
        check({10'h000, head_sel}, 12'h000);
        for (int i = 1; i <= DIAG_DEPTH + 1; i++) push(8'(i));
        aux_case(8'h82, 6'h02, 2, {1'b1, ADDR_DIAG_CODE, 8'h02}, 12'h000, 0);
        aux_case(8'h86, 6'h02, 2, {1'b1, ADDR_DIAG_CODE, NO_CODE}, 12'h000, 0);
        results();
    end
endmodule : tb

`default_nettype wire
